/* shared_pin_gpio_regs.vh */
`ifndef SHARED_PIN_GPIO_REGS_VH
`define SHARED_PIN_GPIO_REGS_VH

// data-space addresses of the six registers
`define ADDR_PIN_SELECT_CTRL_A 16'h7090
`define ADDR_PIN_SELECT_CTRL_B 16'h7092
`define ADDR_PORT_A_VALUE_DIR 16'h7098
`define ADDR_PORT_B_VALUE_DIR 16'h709A
`define ADDR_PORT_C_VALUE_DIR 16'h709C
`define ADDR_PORT_D_VALUE_DIR 16'h709E

// register decode codes
`define SEL_NONE 3'h0
`define SEL_CTRL_A 3'h1
`define SEL_CTRL_B 3'h2
`define SEL_PORT_A 3'h4
`define SEL_PORT_B 3'h5
`define SEL_PORT_C 3'h6
`define SEL_PORT_D 3'h7

// field positions inside a port register
`define PORT_DATA_LSB 0
`define PORT_DATA_MSB 7
`define PORT_DIR_LSB 8
`define PORT_DIR_MSB 15

// pin index bases in the flat 32-pin vectors
`define PIN_BASE_A 0
`define PIN_BASE_B 8
`define PIN_BASE_C 16
`define PIN_BASE_D 24

// select bits of control b whose 1 means general-purpose I/O
`define CTRL_B_INVERTED_MASK 16'h0103
// implemented bits of control b (port c, port d pins 0 and 1)
`define CTRL_B_IMPL_MASK 16'h03FF
// port d pins that have a select bit
`define PORT_D_SHARED_MASK 8'h03

// reset values
`define RESET_CTRL_A 16'h0000
`define RESET_CTRL_B 16'h0000
`define RESET_PORT_DATA 8'h00
`define RESET_PORT_DIR 8'h00

`endif

/* gpio_pin_cell.v */
`timescale 1ns/10ps
// one pad: selects between peripheral and general-purpose drive, all outputs registered
module gpio_pin_cell (
  input wire mclk,
  input wire nrst,
  input wire present,
  input wire primary_sel,
  input wire dir_out,
  input wire data_out,
  input wire periph_out,
  input wire periph_oe,
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe,
  output reg periph_in
);

  reg next_pin_out;
  reg next_pin_oe;
  reg next_periph_in;

  // absent pads never drive; the peripheral only sees the pad while it owns it
  always @* begin
    next_pin_out = 1'b0;
    next_pin_oe = 1'b0;
    next_periph_in = 1'b0;
    if (present) begin
      if (primary_sel) begin
        next_pin_out = periph_out;
        next_pin_oe = periph_oe;
        next_periph_in = pin_in;
      end else begin
        next_pin_oe = dir_out;
        next_pin_out = data_out & dir_out;
      end
    end
  end

  // registered pad drive
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      periph_in <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      periph_in <= next_periph_in;
    end
  end

endmodule

/* shared_pin_gpio_mux.v */
// Function
// - A shared pin carries its peripheral when its select bit is 1 and general-purpose I/O when it is 0, except control b bits 0, 1 and 8.
// - In I/O mode a direction bit of 0 makes the pin an input and 1 makes it a driven output.
// - For an output pin, writing its data bit sets the level driven on the pin.
// - For an input pin, reading its data bit returns the level present on the pin.
// - Data and direction bits act on the pin only in I/O mode; otherwise the peripheral owns it.
// - Control register a sits at 7090h with port a selects in bits 0-7 and port b in 8-15; control b at 7092h.
// - The port a, b, c and d data-and-direction registers sit at 7098h, 709Ah, 709Ch and 709Eh.
// - In a port register bit n is the data of pin n and bit n+8 its direction.
// - Control b bits 0-7 select port c and bits 8-9 port d pins 0-1; bits 0, 1 and 8 mean I/O when 1.
// - All six registers are reached by processor reads and writes in the data space.
// - Port d pins 2-7 are always general-purpose I/O on the large package and absent on the small one.
`timescale 1ns/10ps
`include "shared_pin_gpio_regs.vh"

module shared_pin_gpio_mux #(
  parameter large_package = 1
) (
  input wire mclk,
  input wire nrst,
  input wire [15:0] ds_addr,
  input wire ds_wr,
  input wire ds_rd,
  input wire [15:0] ds_wdata,
  output reg [15:0] ds_rdata,
  input wire [31:0] pin_in,
  output wire [31:0] pin_out,
  output wire [31:0] pin_oe,
  input wire [31:0] periph_out,
  input wire [31:0] periph_oe,
  output wire [31:0] periph_in
);

  // register state
  reg [15:0] pin_select_ctrl_a;
  reg [15:0] pin_select_ctrl_b;
  wire [31:0] port_data;
  wire [31:0] port_dir;

  wire [31:0] present_mask;
  wire [31:0] primary_sel;
  wire [15:0] ctrl_b_effective;
  wire [2:0] wr_sel;
  wire [2:0] rd_sel;
  reg [15:0] next_rdata;

  // address decode, shared by the write and read paths
  function [2:0] decode_reg;
    input [15:0] addr;
    begin
      case (addr)
        `ADDR_PIN_SELECT_CTRL_A: decode_reg = `SEL_CTRL_A;
        `ADDR_PIN_SELECT_CTRL_B: decode_reg = `SEL_CTRL_B;
        `ADDR_PORT_A_VALUE_DIR: decode_reg = `SEL_PORT_A;
        `ADDR_PORT_B_VALUE_DIR: decode_reg = `SEL_PORT_B;
        `ADDR_PORT_C_VALUE_DIR: decode_reg = `SEL_PORT_C;
        `ADDR_PORT_D_VALUE_DIR: decode_reg = `SEL_PORT_D;
        default: decode_reg = `SEL_NONE;
      endcase
    end
  endfunction

  assign wr_sel = decode_reg(ds_addr);
  assign rd_sel = decode_reg(ds_addr);

  // small package has no port d pins 2-7 at all
  assign present_mask = (large_package != 0) ? 32'hFFFFFFFF : 32'h03FFFFFF;

  // control b with the three flag/branch/clock bits turned to primary-high sense
  assign ctrl_b_effective = (pin_select_ctrl_b ^ `CTRL_B_INVERTED_MASK) & `CTRL_B_IMPL_MASK;

  // per-pin primary selection; dedicated port d pins never have a peripheral
  assign primary_sel[15:0] = pin_select_ctrl_a;
  assign primary_sel[23:16] = ctrl_b_effective[7:0];
  assign primary_sel[31:24] = {6'h00, ctrl_b_effective[9:8]};

  // control register writes; unused control b bits are never stored
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_select_ctrl_a <= `RESET_CTRL_A;
      pin_select_ctrl_b <= `RESET_CTRL_B;
    end else if (ds_wr) begin
      if (wr_sel == `SEL_CTRL_A) begin
        pin_select_ctrl_a <= ds_wdata;
      end
      if (wr_sel == `SEL_CTRL_B) begin
        pin_select_ctrl_b <= ds_wdata & `CTRL_B_IMPL_MASK;
      end
    end
  end

  // port register writes, one slice per port; each slice owns its flops so no vector has two drivers
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : port_regs
      localparam integer port_code = `SEL_PORT_A + p;
      wire [7:0] slice_mask;
      reg [7:0] slice_data;
      reg [7:0] slice_dir;
      assign slice_mask = present_mask[p * 8 +: 8];
      assign port_data[p * 8 +: 8] = slice_data;
      assign port_dir[p * 8 +: 8] = slice_dir;
      always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          slice_data <= `RESET_PORT_DATA;
          slice_dir <= `RESET_PORT_DIR;
        end else if (ds_wr && (wr_sel == port_code[2:0])) begin
          // data written while an input is kept, so it drives once the pin turns output
          slice_data <= ds_wdata[`PORT_DATA_MSB:`PORT_DATA_LSB] & slice_mask;
          slice_dir <= ds_wdata[`PORT_DIR_MSB:`PORT_DIR_LSB] & slice_mask;
        end
      end
    end
  endgenerate

  // value seen by a data read: pad level for inputs, latch for outputs
  wire [31:0] data_view;
  assign data_view = ((pin_in & ~port_dir) | (port_data & port_dir)) & present_mask;

  // read mux; unmapped addresses answer zero
  always @* begin
    next_rdata = 16'h0000;
    case (rd_sel)
      `SEL_CTRL_A: next_rdata = pin_select_ctrl_a;
      `SEL_CTRL_B: next_rdata = pin_select_ctrl_b;
      `SEL_PORT_A: next_rdata = {port_dir[7:0], data_view[7:0]};
      `SEL_PORT_B: next_rdata = {port_dir[15:8], data_view[15:8]};
      `SEL_PORT_C: next_rdata = {port_dir[23:16], data_view[23:16]};
      `SEL_PORT_D: next_rdata = {port_dir[31:24], data_view[31:24]};
      default: next_rdata = 16'h0000;
    endcase
  end

  // read data is held until the next read strobe
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ds_rdata <= 16'h0000;
    end else if (ds_rd) begin
      ds_rdata <= next_rdata;
    end
  end

  // one registered cell per pad
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : pads
      gpio_pin_cell u_cell (
        .mclk(mclk),
        .nrst(nrst),
        .present(present_mask[i]),
        .primary_sel(primary_sel[i]),
        .dir_out(port_dir[i]),
        .data_out(port_data[i]),
        .periph_out(periph_out[i]),
        .periph_oe(periph_oe[i]),
        .pin_in(pin_in[i]),
        .pin_out(pin_out[i]),
        .pin_oe(pin_oe[i]),
        .periph_in(periph_in[i])
      );
    end
  endgenerate

endmodule

/* pad_model.sv */
`timescale 1ns/10ps
// pads: a driven pad reads its own drive, else the board level
module pad_model (
  input wire [31:0] pin_out,
  input wire [31:0] pin_oe,
  input wire [31:0] board,
  output wire [31:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board);
endmodule

/* shared_pin_gpio_mux_sva.sv */
`timescale 1ns/10ps
module shared_pin_gpio_mux_sva #(parameter large_package = 1) (
  input wire mclk,
  input wire nrst,
  input wire [15:0] ds_addr,
  input wire ds_wr,
  input wire ds_rd,
  input wire [15:0] ds_wdata,
  input wire [15:0] ds_rdata,
  input wire [31:0] pin_in,
  input wire [31:0] pin_out,
  input wire [31:0] pin_oe,
  input wire [31:0] periph_out,
  input wire [31:0] periph_oe,
  input wire [31:0] periph_in
);
  reg [15:0] sh_a;
  reg [15:0] sh_b;
  reg [15:0] sh_p;
  // shadows of control a, control b and port a, updated with the design
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sh_a <= 16'h0000;
      sh_b <= 16'h0000;
      sh_p <= 16'h0000;
    end else if (ds_wr) begin
      if (ds_addr == 16'h7090) sh_a <= ds_wdata;
      if (ds_addr == 16'h7092) sh_b <= ds_wdata;
      if (ds_addr == 16'h7098) sh_p <= ds_wdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_primary_drive: assert property (sh_a[8] |=> pin_oe[8] == $past(periph_oe[8]) &&
    pin_out[8] == $past(periph_out[8]) && periph_in[8] == $past(pin_in[8])) else $error("primary pad wrong");
  a_io_drive: assert property (ds_wr && ds_addr == 16'h7098 && !sh_a[0] ##1 !ds_wr |=>
    pin_oe[0] == $past(ds_wdata[8], 2) && pin_out[0] == ($past(ds_wdata[8], 2) & $past(ds_wdata[0], 2)))
    else $error("io drive wrong");
  a_input_read: assert property (ds_rd && ds_addr == 16'h7098 && !sh_a[2] && !sh_p[10] |=>
    ds_rdata[2] == $past(pin_in[2]) && ds_rdata[15:8] == $past(sh_p[15:8])) else $error("input read wrong");
  a_io_periph_zero: assert property (!sh_a[1] |=> periph_in[1] == 1'b0) else $error("periph_in leak");
  a_ctrl_b_polarity: assert property (!sh_b[0] |=> pin_oe[16] == $past(periph_oe[16])) else $error("ctrl b");
  a_reserved_zero: assert property (ds_rd && ds_addr == 16'h7092 |=> ds_rdata[15:10] == 6'h00)
    else $error("reserved bits set");
  a_unmapped_zero: assert property (ds_rd && !(ds_addr inside {16'h7090, 16'h7092, 16'h7098, 16'h709A,
    16'h709C, 16'h709E}) |=> ds_rdata == 16'h0000) else $error("unmapped read");
  a_rdata_holds: assert property (!ds_rd |=> $stable(ds_rdata)) else $error("rdata moved");
  a_absent_quiet: assert property (large_package == 0 |-> pin_oe[31:26] == 6'h00 && pin_out[31:26] == 6'h00)
    else $error("absent pad driven");
  cover property (ds_rd && ds_addr == 16'h7098);
  cover property (sh_a[8] && periph_oe[8]);
  cover property (ds_wr && ds_addr == 16'h7092);
endmodule
bind shared_pin_gpio_mux shared_pin_gpio_mux_sva #(.large_package(large_package)) shared_pin_gpio_mux_sva_inst (
  .mclk(mclk), .nrst(nrst), .ds_addr(ds_addr), .ds_wr(ds_wr), .ds_rd(ds_rd), .ds_wdata(ds_wdata),
  .ds_rdata(ds_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
  .periph_oe(periph_oe), .periph_in(periph_in));

/* shared_pin_gpio_mux_tb.sv */
`timescale 1ns/10ps
module shared_pin_gpio_mux_tb;
  reg mclk = 1'b0;
  reg nrst = 1'b0;
  reg [15:0] ds_addr = 16'h0000;
  reg ds_wr = 1'b0;
  reg ds_rd = 1'b0;
  reg [15:0] ds_wdata = 16'h0000;
  reg [31:0] board = 32'h00000000;
  reg [31:0] periph_out = 32'h00000000;
  reg [31:0] periph_oe = 32'h00000000;
  wire [15:0] ds_rdata;
  wire [31:0] pin_in, pin_out, pin_oe, periph_in;
  wire [15:0] small_rdata;
  wire [31:0] small_out, small_oe, small_periph_in;
  integer mismatches = 0;
  integer total_checks = 0;
  integer i;
  reg [15:0] q;
  // rows: address, write data, board levels, expected read
  reg [79:0] rows [0:8];
  shared_pin_gpio_mux shared_pin_gpio_mux_inst (.mclk(mclk), .nrst(nrst), .ds_addr(ds_addr), .ds_wr(ds_wr),
    .ds_rd(ds_rd), .ds_wdata(ds_wdata), .ds_rdata(ds_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in));
  pad_model pad_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .board(board), .pin_in(pin_in));
  // small package copy on the same bus; its port d pins 2-7 must stay dead
  shared_pin_gpio_mux #(.large_package(0)) shared_pin_gpio_mux_small_inst (.mclk(mclk), .nrst(nrst),
    .ds_addr(ds_addr), .ds_wr(ds_wr), .ds_rd(ds_rd), .ds_wdata(ds_wdata), .ds_rdata(small_rdata), .pin_in(board),
    .pin_out(small_out), .pin_oe(small_oe), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(small_periph_in));
  initial begin
    forever #50 mclk = ~mclk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // read data compare
  task chk_rd(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t read %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one-cycle strobes, driven on the falling edge
  task wr(input [15:0] a, input [15:0] d);
    begin
      @(negedge mclk);
      ds_addr = a;
      ds_wdata = d;
      ds_wr = 1'b1;
      @(negedge mclk);
      ds_wr = 1'b0;
    end
  endtask
  task rd(input [15:0] a);
    begin
      @(negedge mclk);
      ds_addr = a;
      ds_rd = 1'b1;
      @(negedge mclk);
      ds_rd = 1'b0;
      q = ds_rdata;
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // no wait below is open-ended; this only cuts a hang
  initial begin
    #200000;
    mismatches = mismatches + 1;
    finish_test;
  end
  initial begin
    rows[0] = {16'h7090, 16'h5AA5, 32'h00000000, 16'h5AA5};
    rows[1] = {16'h7090, 16'h0000, 32'h00000000, 16'h0000};
    rows[2] = {16'h7092, 16'hFFFF, 32'h00000000, 16'h03FF};
    rows[3] = {16'h7092, 16'h0103, 32'h00000000, 16'h0103};
    rows[4] = {16'h7098, 16'hFF5A, 32'h000000A5, 16'hFF5A};
    rows[5] = {16'h709A, 16'h0F03, 32'h0000CF00, 16'h0FC3};
    rows[6] = {16'h709C, 16'h0000, 32'h00960000, 16'h0096};
    rows[7] = {16'h709E, 16'hFC00, 32'hFF000000, 16'hFC03};
    rows[8] = {16'h7094, 16'hFFFF, 32'h00000000, 16'h0000};
    repeat (3) @(posedge mclk);
    @(negedge mclk) nrst = 1'b1;
    rd(16'h7092);
    chk_rd(q, 16'h0000);
    for (i = 0; i < 9; i = i + 1) begin
      board = rows[i][47:16];
      wr(rows[i][79:64], rows[i][63:48]);
      rd(rows[i][79:64]);
      chk_rd(q, rows[i][15:0]);
    end
    // outputs of the io pins, including port d pins 2 to 7
    chk(pin_oe, 32'hFC000FFF);
    chk(pin_out, 32'h0000035A);
    chk(small_oe, 32'h00000FFF);
    chk(small_out, 32'h0000035A);
    // port d read with inputs high: small copy drops pins 2-7
    board = 32'hFF000000;
    rd(16'h709E);
    chk_rd(q, 16'hFC03);
    chk_rd(small_rdata, 16'h0003);
    periph_oe = 32'hFFFFFFFF;
    periph_out = 32'h5555AAAA;
    wr(16'h7090, 16'hFF00);
    wr(16'h7092, 16'h0000);
    repeat (2) @(negedge mclk);
    chk(pin_oe, 32'hFD03FFFF);
    chk(pin_out, 32'h0101AA5A);
    chk(periph_in, 32'h0101AA00);
    chk(small_oe, 32'h0103FFFF);
    chk(small_periph_in, 32'h01000000);
    // reset in mid-run clears the pads and registers
    @(negedge mclk) nrst = 1'b0;
    @(negedge mclk) chk(pin_oe, 32'h00000000);
    nrst = 1'b1;
    board = 32'h000000C3;
    rd(16'h7098);
    chk_rd(q, 16'h00C3);
    chk(pin_oe, 32'h01030000);
    finish_test;
  end
endmodule
